// [logic/scc_channel.sv]
// one transceiver channel: power sequencing, framing serializer, loopback, receive lock
// assumes synchronous pins, reference_clock period of one frame (20 mclk cycles), one bit per mclk
`timescale 1ns/1ps
`include "scc_cfg.svh"

// What this block does
// R1 - with power enable low the channel idles and releases serial outputs and receive data.
// R2 - the controlling logic should hold power enable low until its supply has settled.
// R3 - the bit clock is ten times the reference with both edges used, so a frame is twenty bits per reference period.
// R4 - the reference clock must run for reception too, and the receiver follows the reference-derived rate within 200 ppm.
// R5 - the controlling logic keeps each reference within 100 ppm and between 1.0 and 2.5 Gbps serial rate.
// R6 - loopback feeds the transmit stream into the receiver and releases the serial output.
// R7 - after reset a power-on phase under 1 ms keeps receive data released and the word clock low.
// R8 - after power enable rises the PLL locks within 0.4 ms, here at the typical 0.1 ms.
// R9 - the receiver acquires framing within a typical 1024 bit times.
// R10 - lock shows only while recovered words are valid and drops when framing is lost.
// R11 - every control and clock of this channel acts on this instance alone.
module scc_channel #(
    parameter int POR_CYCLES = `SCC_POR_MAX_US * `SCC_CLK_MHZ - 1,
    parameter int PLL_CYCLES = `SCC_PLL_TYP_US * `SCC_CLK_MHZ,
    parameter int WORD_BITS  = `SCC_WORD_BITS,
    parameter int FIFO_DEPTH = `SCC_FIFO_DEPTH
) (
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    input  wire logic                 channel_power_enable,
    input  wire logic                 serial_loopback_enable,
    input  wire logic                 reference_clock,
    input  wire logic [WORD_BITS-1:0] transmit_data_bus,
    input  wire logic                 transmit_valid,
    output logic                      transmit_ready,
    input  wire logic                 serial_in_positive,
    output logic                      serial_out_positive,
    output logic                      serial_out_negative,
    output logic                      serial_out_oe,
    output logic      [WORD_BITS-1:0] receive_data_bus,
    output logic                      receive_data_oe,
    output logic                      recovered_word_clock,
    output logic                      recovered_word_clock_oe,
    output logic                      receiver_lock_indicator,
    output logic                      pll_locked,
    output logic                      acquire_timeout,
    output scc_pkg::scc_pwr_t         power_state
);
    import scc_pkg::*;

    localparam int FB = WORD_BITS + 2;
    localparam int CW = 18;
    localparam logic [CW-1:0] POR_LAST  = CW'(POR_CYCLES - 1);
    localparam logic [CW-1:0] PLL_LAST  = CW'(PLL_CYCLES - 1);
    localparam logic [4:0]    PH_LAST   = 5'(FB - 1);
    localparam logic [4:0]    PH_HALF   = 5'(FB / 2);
    localparam logic [7:0]    REF_GAP   = 8'(`SCC_REF_GAP);
    localparam logic [10:0]   ACQ_LAST  = 11'(`SCC_ACQ_BITS - 1);
    localparam logic [2:0]    LOCK_LAST = 3'(`SCC_LOCK_FRAMES - 1);
    localparam logic [2:0]    LOSS_LAST = 3'(`SCC_LOSS_FRAMES - 1);
    localparam logic [3:0]    HOLD_LAST = 4'(`SCC_HOLD_FRAMES - 1);

    // power sequencing state
    scc_pwr_t        st_r;
    scc_pwr_t        st_nxt;
    logic [CW-1:0]   cnt_r;
    logic [CW-1:0]   cnt_nxt;
    logic            ref_q_r;
    logic [7:0]      gap_r;
    logic [7:0]      gap_nxt;
    logic            ref_rise;
    logic            ref_alive;
    logic            run;

    assign ref_rise  = reference_clock && !ref_q_r;
    assign ref_alive = (gap_r < REF_GAP);
    assign run       = (st_r == SCC_PWR_RUN);

    always_comb begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        // a stalled reference keeps the pll, and thus the receiver, out of service
        gap_nxt = ref_rise ? 8'h00 : (ref_alive ? gap_r + 8'h01 : gap_r); // R4
        case (st_r)
            SCC_PWR_POR: begin
                cnt_nxt = cnt_r + 1'h1; // R7
                if (cnt_r == POR_LAST) begin
                    st_nxt  = SCC_PWR_DOWN;
                    cnt_nxt = '0;
                end
            end
            SCC_PWR_DOWN: begin
                cnt_nxt = '0;
                if (channel_power_enable) begin
                    st_nxt = SCC_PWR_PLL; // R8
                end
            end
            SCC_PWR_PLL: begin
                if (!channel_power_enable) begin
                    st_nxt = SCC_PWR_DOWN; // R1
                end else if (!ref_alive) begin
                    cnt_nxt = '0; // R4
                end else if (cnt_r == PLL_LAST) begin
                    st_nxt  = SCC_PWR_RUN; // R8
                    cnt_nxt = '0;
                end else begin
                    cnt_nxt = cnt_r + 1'h1; // R8
                end
            end
            SCC_PWR_RUN: begin
                if (!channel_power_enable) begin
                    st_nxt = SCC_PWR_DOWN; // R1
                end else if (!ref_alive) begin
                    st_nxt = SCC_PWR_PLL; // R4
                end
            end
            default: begin
                st_nxt  = SCC_PWR_POR;
                cnt_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_r    <= SCC_PWR_POR;
            cnt_r   <= '0;
            ref_q_r <= 1'h0;
            gap_r   <= REF_GAP;
        end else begin
            st_r    <= st_nxt;
            cnt_r   <= cnt_nxt;
            ref_q_r <= reference_clock;
            gap_r   <= gap_nxt;
        end
    end

    // transmit path: a word per reference edge into the buffer, a frame per twenty bits out
    logic [WORD_BITS-1:0] fifo_data;
    logic                 fifo_valid;
    logic                 fifo_in_ready;
    logic                 tx_load;
    logic [4:0]           tx_ph_r;
    logic [4:0]           tx_ph_nxt;
    logic [FB-1:0]        tx_sr_r;
    logic [FB-1:0]        tx_sr_nxt;

    assign tx_load        = run && (tx_ph_r == PH_LAST);
    assign transmit_ready = run && fifo_in_ready;

    scc_fifo #(
        .WIDTH (WORD_BITS),
        .DEPTH (FIFO_DEPTH)
    ) u_tx_fifo (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .clr       (!run),
        .in_valid  (run && ref_rise && transmit_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (transmit_data_bus),
        .out_valid (fifo_valid),
        .out_ready (tx_load),
        .out_data  (fifo_data)
    );

    always_comb begin
        tx_ph_nxt = '0;
        tx_sr_nxt = '0;
        if (run) begin
            tx_ph_nxt = tx_load ? 5'h00 : tx_ph_r + 5'h01; // R3
            // an empty buffer still sends a framed zero word so the far receiver keeps lock
            if (tx_load) begin
                tx_sr_nxt = {`SCC_STOP_BIT, (fifo_data & {WORD_BITS{fifo_valid}}), `SCC_START_BIT}; // R3
            end else begin
                tx_sr_nxt = {1'h0, tx_sr_r[FB-1:1]};
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tx_ph_r <= '0;
            tx_sr_r <= '0;
        end else begin
            tx_ph_r <= tx_ph_nxt;
            tx_sr_r <= tx_sr_nxt;
        end
    end

    assign serial_out_positive = tx_sr_r[0];
    assign serial_out_negative = !tx_sr_r[0];
    assign serial_out_oe       = run && !serial_loopback_enable; // R1 R6

    // receive path: frame hunt, lock, loss and hold-off
    scc_rx_t              rx_st_r;
    scc_rx_t              rx_st_nxt;
    logic [FB-1:0]        rx_sr_r;
    logic [FB-1:0]        rx_sr_nxt;
    logic [4:0]           rx_ph_r;
    logic [4:0]           rx_ph_nxt;
    logic [2:0]           hits_r;
    logic [2:0]           hits_nxt;
    logic [3:0]           hold_r;
    logic [3:0]           hold_nxt;
    logic [10:0]          acq_r;
    logic [10:0]          acq_nxt;
    logic                 acq_to_r;
    logic                 acq_to_nxt;
    logic [WORD_BITS-1:0] rdata_r;
    logic [WORD_BITS-1:0] rdata_nxt;
    logic                 wclk_r;
    logic                 wclk_nxt;
    logic                 rx_bit;
    logic                 at_edge;
    logic                 frame_ok;

    assign rx_bit   = serial_loopback_enable ? tx_sr_r[0] : serial_in_positive; // R6
    assign at_edge  = (rx_ph_r == PH_LAST);

    always_comb begin
        rx_sr_nxt  = {rx_bit, rx_sr_r[FB-1:1]};
        frame_ok   = (rx_sr_nxt[0] == `SCC_START_BIT) && (rx_sr_nxt[FB-1] == `SCC_STOP_BIT);
        rx_st_nxt  = rx_st_r;
        rx_ph_nxt  = at_edge ? 5'h00 : rx_ph_r + 5'h01;
        hits_nxt   = hits_r;
        hold_nxt   = hold_r;
        acq_nxt    = acq_r;
        acq_to_nxt = acq_to_r;
        rdata_nxt  = rdata_r;
        case (rx_st_r)
            SCC_RX_HUNT: begin
                acq_nxt = (acq_r == ACQ_LAST) ? acq_r : acq_r + 11'h001;
                if (acq_r == ACQ_LAST) begin
                    acq_to_nxt = 1'h1; // R9
                end
                if (at_edge) begin
                    if (frame_ok) begin
                        hits_nxt = hits_r + 3'h1;
                        if (hits_r == LOCK_LAST) begin
                            rx_st_nxt  = SCC_RX_LOCK; // R10
                            hits_nxt   = '0;
                            acq_to_nxt = 1'h0;
                            rdata_nxt  = rx_sr_nxt[FB-2:1];
                        end
                    end else begin
                        // slip one bit so every position is tried
                        hits_nxt  = '0;
                        rx_ph_nxt = PH_LAST; // R9
                    end
                end
            end
            SCC_RX_LOCK: begin
                if (at_edge) begin
                    rdata_nxt = rx_sr_nxt[FB-2:1];
                    hits_nxt  = frame_ok ? 3'h0 : hits_r + 3'h1;
                    if (!frame_ok && hits_r == LOSS_LAST) begin
                        rx_st_nxt = SCC_RX_HOLD; // R10
                        hits_nxt  = '0;
                        hold_nxt  = '0;
                    end
                end
            end
            SCC_RX_HOLD: begin
                if (at_edge) begin
                    hold_nxt = hold_r + 4'h1;
                    if (hold_r == HOLD_LAST) begin
                        rx_st_nxt = SCC_RX_HUNT; // R10
                        acq_nxt   = '0;
                    end
                end
            end
            default: begin
                rx_st_nxt = SCC_RX_HUNT;
            end
        endcase
        wclk_nxt = (rx_st_nxt == SCC_RX_LOCK) && (rx_ph_nxt < PH_HALF);
        // receiver needs pll phases, so it idles until the pll is up
        if (!run) begin
            rx_st_nxt  = SCC_RX_HUNT; // R4
            rx_sr_nxt  = '0;
            rx_ph_nxt  = '0;
            hits_nxt   = '0;
            hold_nxt   = '0;
            acq_nxt    = '0;
            acq_to_nxt = 1'h0;
            rdata_nxt  = '0;
            wclk_nxt   = 1'h0; // R7
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_st_r  <= SCC_RX_HUNT;
            rx_sr_r  <= '0;
            rx_ph_r  <= '0;
            hits_r   <= '0;
            hold_r   <= '0;
            acq_r    <= '0;
            acq_to_r <= 1'h0;
            rdata_r  <= '0;
            wclk_r   <= 1'h0;
        end else begin
            rx_st_r  <= rx_st_nxt;
            rx_sr_r  <= rx_sr_nxt;
            rx_ph_r  <= rx_ph_nxt;
            hits_r   <= hits_nxt;
            hold_r   <= hold_nxt;
            acq_r    <= acq_nxt;
            acq_to_r <= acq_to_nxt;
            rdata_r  <= rdata_nxt;
            wclk_r   <= wclk_nxt;
        end
    end

    // all state is local, so four instances run fully apart
    assign receiver_lock_indicator = run && (rx_st_r == SCC_RX_LOCK); // R10 R11
    assign receive_data_oe         = receiver_lock_indicator; // R1 R7
    assign recovered_word_clock_oe = receiver_lock_indicator;
    assign receive_data_bus        = rdata_r;
    assign recovered_word_clock    = wclk_r; // R7
    assign pll_locked              = run;
    assign acquire_timeout         = acq_to_r;
    assign power_state             = st_r;

endmodule : scc_channel

// [logic/scc_cfg.svh]
// timing counts, frame layout and sizes for one serdes channel controller
// assumes the includer compiles with a 250 MHz mclk
`ifndef SCC_CFG_SVH
`define SCC_CFG_SVH

`define SCC_WORD_BITS       18
`define SCC_BIT_MULT        10
`define SCC_EDGES_PER_BIT   2
`define SCC_FRAME_BITS      (`SCC_BIT_MULT * `SCC_EDGES_PER_BIT)
`define SCC_START_BIT       1'h1
`define SCC_STOP_BIT        1'h0
`define SCC_CLK_MHZ         250
`define SCC_POR_MAX_US      1000
`define SCC_PLL_TYP_US      100
`define SCC_PLL_MAX_US      400
`define SCC_TRACK_PPM       200
`define SCC_REF_TOL_PPM     100
`define SCC_ACQ_BITS        1024
`define SCC_LOCK_FRAMES     4
`define SCC_LOSS_FRAMES     4
`define SCC_HOLD_FRAMES     9
`define SCC_REF_GAP         40
`define SCC_FIFO_DEPTH      32

`endif

// [logic/scc_pkg.sv]
// state types for the serdes channel controller
// assumes scc_cfg.svh carries every number
package scc_pkg;

    typedef enum logic [3:0] {
        SCC_PWR_POR  = 4'h1,
        SCC_PWR_DOWN = 4'h2,
        SCC_PWR_PLL  = 4'h4,
        SCC_PWR_RUN  = 4'h8
    } scc_pwr_t;

    typedef enum logic [2:0] {
        SCC_RX_HUNT = 3'h1,
        SCC_RX_LOCK = 3'h2,
        SCC_RX_HOLD = 3'h4
    } scc_rx_t;

endpackage : scc_pkg

// [logic/scc_fifo.sv]
// first-in first-out buffer with valid/ready on both sides and a flush
// assumes one clock, DEPTH a power of two
`timescale 1ns/1ps

module scc_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 32
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic             clr,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_r;
    logic [AW:0]      wr_nxt;
    logic [AW:0]      rd_r;
    logic [AW:0]      rd_nxt;
    logic             push;
    logic             pop;

    // extra pointer bit tells full from empty
    assign in_ready  = (wr_r[AW] == rd_r[AW]) || (wr_r[AW-1:0] != rd_r[AW-1:0]);
    assign out_valid = (wr_r != rd_r);
    assign out_data  = mem[rd_r[AW-1:0]];
    assign push      = in_valid && in_ready && !clr;
    assign pop       = out_valid && out_ready && !clr;

    always_comb begin
        wr_nxt = clr ? '0 : (push ? wr_r + 1'h1 : wr_r);
        rd_nxt = clr ? '0 : (pop ? rd_r + 1'h1 : rd_r);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_r <= '0;
            rd_r <= '0;
        end else begin
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
        end
    end

    // storage has no reset; empty pointers hide its content
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_r[AW-1:0]] <= in_data;
        end
    end

endmodule : scc_fifo

// [tb/scc_channel_monitor.sv]
// assertion checker for one serdes channel controller
// assumes it is bound into scc_channel and sees only its ports
`timescale 1ns/1ps

module scc_channel_monitor
    import scc_pkg::*;
#(
    parameter int POR_CYCLES = 20,
    parameter int PLL_CYCLES = 30,
    parameter int WORD_BITS  = 18
) (
    input wire logic                 mclk,
    input wire logic                 rst_n,
    input wire logic                 channel_power_enable,
    input wire logic                 serial_loopback_enable,
    input wire logic                 serial_out_oe,
    input wire logic                 receive_data_oe,
    input wire logic                 recovered_word_clock,
    input wire logic                 recovered_word_clock_oe,
    input wire logic                 receiver_lock_indicator,
    input wire logic                 pll_locked,
    input wire logic                 acquire_timeout,
    input wire scc_pkg::scc_pwr_t    power_state
);
    int por_cnt_r;
    int pll_cnt_r;
    int wclk_hi_r;

    // cycles spent in the current power-on or pll phase, and in the current word clock high
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            por_cnt_r <= 0;
            pll_cnt_r <= 0;
            wclk_hi_r <= 0;
        end else begin
            por_cnt_r <= (power_state == SCC_PWR_POR) ? por_cnt_r + 1 : 0;
            pll_cnt_r <= (power_state == SCC_PWR_PLL) ? pll_cnt_r + 1 : 0;
            wclk_hi_r <= recovered_word_clock ? wclk_hi_r + 1 : 0;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    down_quiet_a: assert property (power_state != SCC_PWR_RUN |-> !serial_out_oe && !receive_data_oe)
        else $error("outputs driven outside run");
    disable_drop_a: assert property (!channel_power_enable && power_state inside {SCC_PWR_PLL, SCC_PWR_RUN}
        |=> power_state == SCC_PWR_DOWN) else $error("power enable low did not power down");
    // own disable: a power or reference loss may cut a frame short
    word_clock_a: assert property (disable iff (!rst_n || !pll_locked || !channel_power_enable)
        $fell(recovered_word_clock) |-> wclk_hi_r == 10)
        else $error("word clock high time not ten cycles");
    loop_release_a: assert property (serial_loopback_enable |-> !serial_out_oe)
        else $error("serial output driven in loopback");
    run_drive_a: assert property (power_state == SCC_PWR_RUN && !serial_loopback_enable |-> serial_out_oe)
        else $error("serial output not driven in run");
    por_quiet_a: assert property (power_state == SCC_PWR_POR
        |-> !receive_data_oe && !recovered_word_clock && por_cnt_r <= POR_CYCLES + 1)
        else $error("power-on phase too long or not quiet");
    pll_wait_a: assert property ($rose(pll_locked) |-> pll_cnt_r >= PLL_CYCLES - 1)
        else $error("pll lock came early");
    lock_oe_a: assert property ((receive_data_oe == receiver_lock_indicator)
        && (recovered_word_clock_oe == receiver_lock_indicator) && (!receiver_lock_indicator || pll_locked))
        else $error("lock and output enables disagree");
    lock_hold_a: assert property ($fell(receiver_lock_indicator) |-> !receiver_lock_indicator [*8])
        else $error("lock came back too soon");
    timeout_clear_a: assert property (receiver_lock_indicator [*2] |-> !acquire_timeout)
        else $error("acquire timeout stays set while locked");
endmodule : scc_channel_monitor

bind scc_channel scc_channel_monitor #(.POR_CYCLES(POR_CYCLES), .PLL_CYCLES(PLL_CYCLES), .WORD_BITS(WORD_BITS))
    scc_channel_monitor_i (.mclk(mclk), .rst_n(rst_n), .channel_power_enable(channel_power_enable),
    .serial_loopback_enable(serial_loopback_enable), .serial_out_oe(serial_out_oe),
    .receive_data_oe(receive_data_oe), .recovered_word_clock(recovered_word_clock),
    .recovered_word_clock_oe(recovered_word_clock_oe), .receiver_lock_indicator(receiver_lock_indicator),
    .pll_locked(pll_locked), .acquire_timeout(acquire_timeout), .power_state(power_state));

// [tb/scc_ref_source.sv]
// reference clock and transmit word source standing for the protocol device
// assumes the bench feeds next_word and records took_word when took is high
`timescale 1ns/1ps

module scc_ref_source (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        ref_run,
    input  wire logic        pll_locked,
    input  wire logic        transmit_ready,
    input  wire logic [17:0] next_word,
    output logic             reference_clock,
    output logic [17:0]      transmit_data_bus,
    output logic             transmit_valid,
    output logic             took,
    output logic [17:0]      took_word
);
    int   ph = 0;
    logic ref_d = 1'b0;
    logic take;

    initial begin
        reference_clock = 1'b0;
        transmit_data_bus = 18'h00000;
        transmit_valid = 1'b0;
        took = 1'b0;
        took_word = 18'h00000;
    end

    always begin
        @(posedge mclk);
        take = reference_clock && !ref_d && pll_locked && transmit_valid && transmit_ready;
        ref_d = reference_clock;
        #1;
        took = take;
        // word held until the edge that takes it
        if (take) begin
            took_word = transmit_data_bus;
            transmit_data_bus = next_word;
        end
        transmit_valid = rst_n;
        ph = (ph == 19) ? 0 : ph + 1;
        // runs even when only receiving; stop only on request
        reference_clock = ref_run && (ph < 10);
    end
endmodule : scc_ref_source

// [tb/serdes_channel_control_test.sv]
// self-checking bench for one serdes channel controller
// assumes short power-on and pll counts; external loop ties serial out to serial in
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, (g), (e)); end end

module serdes_channel_control_test;
    import scc_pkg::*;
    localparam int POR_C = 20;
    localparam int PLL_C = 30;
    logic mclk = 0, rst_n = 0, en = 0, loop_en = 0, ref_run = 1, ext_loop = 0;
    logic chk_rx = 0, synced = 0, ref_clk, tx_valid, tx_ready, took, sout, soutn, sin, so_oe;
    logic rd_oe, rwc, rwc_oe, lock, pll_locked, acq_to;
    logic [17:0] tx_data, took_word, next_word, rd, exp_w;
    logic [17:0] words [256];
    logic [17:0] q [$];
    scc_pwr_t power_state;
    int n_fail = 0, compares = 0, cyc = 0, n_sent = 0, n_rx = 0;

    always #2 mclk = ~mclk;
    assign sin = ext_loop ? sout : 1'b0;

    scc_ref_source scc_ref_source_i (.mclk(mclk), .rst_n(rst_n), .ref_run(ref_run), .pll_locked(pll_locked),
        .transmit_ready(tx_ready), .next_word(next_word), .reference_clock(ref_clk),
        .transmit_data_bus(tx_data), .transmit_valid(tx_valid), .took(took), .took_word(took_word));

    scc_channel #(.POR_CYCLES(POR_C), .PLL_CYCLES(PLL_C)) scc_channel_i (.mclk(mclk), .rst_n(rst_n),
        .channel_power_enable(en), .serial_loopback_enable(loop_en), .reference_clock(ref_clk),
        .transmit_data_bus(tx_data), .transmit_valid(tx_valid), .transmit_ready(tx_ready),
        .serial_in_positive(sin), .serial_out_positive(sout), .serial_out_negative(soutn), .serial_out_oe(so_oe),
        .receive_data_bus(rd), .receive_data_oe(rd_oe), .recovered_word_clock(rwc),
        .recovered_word_clock_oe(rwc_oe), .receiver_lock_indicator(lock), .pll_locked(pll_locked),
        .acquire_timeout(acq_to), .power_state(power_state));

    function automatic logic exp_drive(logic run, logic lp);
        return run && !lp;
    endfunction : exp_drive

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim

    // edges until the signal reads high, or lim
    task automatic wait_for(ref logic s, input int lim, output int n);
        n = 0;
        while (s !== 1'b1 && n < lim) begin
            @(posedge mclk);
            #1;
            n++;
        end
    endtask : wait_for

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            end_sim;
        end
        if (took) begin
            q.push_back(took_word);
            n_sent++;
            next_word = words[n_sent % 256];
        end
    end

    // words lost before lock are skipped once, then order must hold
    always @(negedge rwc) begin
        if (chk_rx) begin
            while (!synced && q.size() > 1 && q[0] !== rd) void'(q.pop_front());
            synced = 1;
            n_rx++;
            // popped once; the macro reads its expected value twice
            exp_w = q.pop_front();
            `CHK(rd, exp_w)
            `CHK(soutn, !sout)
        end
    end

    initial begin
        int n;
        void'($urandom(93));
        foreach (words[i]) words[i] = 18'($urandom);
        // corners placed after lock, so the pre-lock skip cannot match them
        words[30] = 18'h3FFFF;
        words[31] = 18'h00000;
        words[32] = 18'h20001;
        next_word = words[0];
        repeat (16) @(posedge mclk);
        #1 rst_n = 1;
        `CHK(power_state, SCC_PWR_POR)
        `CHK({so_oe, rd_oe, rwc}, 3'h0)
        repeat (POR_C + 4) @(posedge mclk);
        #1;
        `CHK(power_state, SCC_PWR_DOWN)
        `CHK({so_oe, rd_oe, tx_ready}, 3'h0)
        en = 1;
        wait_for(pll_locked, 200, n);
        `CHK(n >= PLL_C && n <= PLL_C + 2, 1'b1)
        loop_en = 1;
        @(posedge mclk);
        #1;
        `CHK(so_oe, exp_drive(1'b1, loop_en))
        wait_for(lock, 1100, n);
        `CHK(n <= 1024, 1'b1)
        `CHK({rd_oe, acq_to}, 2'h2)
        chk_rx = 1;
        repeat (400) @(posedge mclk);
        #1 ext_loop = 1;
        loop_en = 0;
        repeat (400) @(posedge mclk);
        #1;
        `CHK(so_oe, exp_drive(1'b1, loop_en))
        `CHK(n_rx >= 39 && n_rx <= 41, 1'b1)
        chk_rx = 0;
        ext_loop = 0;
        repeat (110) @(posedge mclk);
        #1;
        `CHK({lock, rd_oe, rwc_oe}, 3'h0)
        wait_for(acq_to, 2000, n);
        `CHK(acq_to === 1'b1 && n >= 1024 - 110, 1'b1)
        ext_loop = 1;
        wait_for(lock, 1100, n);
        repeat (2) @(posedge mclk);
        #1;
        `CHK({lock, acq_to}, 2'h2)
        ref_run = 0;
        repeat (60) @(posedge mclk);
        #1;
        `CHK({pll_locked, lock, power_state}, {2'h0, SCC_PWR_PLL})
        ref_run = 1;
        wait_for(pll_locked, 200, n);
        `CHK(pll_locked, 1'b1)
        en = 0;
        @(posedge mclk);
        #1;
        `CHK({power_state, so_oe, rd_oe, lock}, {SCC_PWR_DOWN, 3'h0})
        end_sim;
    end
endmodule : serdes_channel_control_test
